// file: rtl/ata_task_file_decode.sv
// How it works
// - Memory mode: A3-A0 pick registers, A10 high gives even/odd bytes by A0.
// - IDE: CS0 picks command block by A2-A0, CS1 with 110 alt/control.
// - DMA acknowledge with both selects high moves 16-bit words.
// - IDE PIO data is a word, or low byte once byte mode is on.
// - Data port lane steering follows the two byte enables and A0.
// - Data port streams sector data to and from the internal buffer.
// - Byte access at offset 1 reaches fault cause, word at 0 data.
// - Offsets 1 and D read fault cause, writes load command option.
// - High-enable-only read at offset 0 puts fault cause on D15-D8.
// - High-enable-only write at offset 0 loads option from D15-D8.
// - Fault cause holds the reason while the status error flag is set.
// - Bit 7 set on bad block or interface CRC error.
// - Bit 6 set on uncorrectable data error.
// - Bit 4 set when the sector identifier is wrong or missing.
// - Bit 2 set when a command is aborted.
// - Bit 0 set on a general error.
// - Bits 5, 3 and 1 of fault cause always read zero.
// - Block count holds sectors to move; zero means 256.
// - Count reads zero on success, else sectors still outstanding.
// - Offset 3 holds start sector or address bits 7-0.
// - Offsets 4 and 5 hold cylinder or address bits 15-8, 23-16.
// - Address-mode flag picks 28-bit block address or cylinder/head/sector.
// - Status error flag set when a command ends in error.
`include "ata_tf_cfg.svh"
module ata_task_file_decode
   import ata_tf_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   // Card personality
   input  wire logic [1:0]  MODE_I,
   input  wire logic        BYTE_MODE_I,
   // Host pins
   input  wire logic        REG_N_I,
   input  wire logic        LOW_BYTE_ENABLE_N_I,
   input  wire logic        HIGH_BYTE_ENABLE_N_I,
   input  wire logic        OE_N_I,
   input  wire logic        WE_N_I,
   input  wire logic        IORD_N_I,
   input  wire logic        IOWR_N_I,
   input  wire logic        CS0_N_I,
   input  wire logic        CS1_N_I,
   input  wire logic        DMACK_N_I,
   input  wire logic [10:0] ADDR_I,
   input  wire logic [15:0] DATA_I,
   output logic [15:0]      DATA_O,
   output logic [15:0]      DATA_OE_N_O,
   // Sector buffer
   input  wire logic [15:0] BUF_RD_DATA_I,
   output logic             BUF_RD_READY_O,
   output logic [15:0]      BUF_WR_DATA_O,
   output logic             BUF_WR_VALID_O,
   // Command engine events
   input  wire logic        BAD_BLOCK_I,
   input  wire logic        CRC_ERR_I,
   input  wire logic        UNCORR_I,
   input  wire logic        ID_NOT_FOUND_I,
   input  wire logic        ABORT_I,
   input  wire logic        GENERAL_ERR_I,
   input  wire logic        SECTOR_DONE_I,
   input  wire logic        CMD_OK_I,
   // Drive/head fields
   input  wire logic        LBA_MODE_I,
   input  wire logic [3:0]  HEAD_I,
   // Registers kept outside this block
   input  wire logic [7:0]  EXT_RDATA_I,
   output logic [3:0]       EXT_OFFSET_O,
   output logic [7:0]       EXT_WDATA_O,
   output logic             EXT_WR_O,
   // Register contents
   output logic [7:0]       FEATURE_O,
   output logic             FEATURE_WR_O,
   output logic [7:0]       SECTOR_COUNT_O,
   output logic [8:0]       SECTOR_TOTAL_O,
   output logic [27:0]      LBA_O,
   output logic [15:0]      CYL_O,
   output logic [7:0]       SECT_O,
   output logic [7:0]       ERROR_O,
   output logic             STATUS_ERR_O
);

   state_t q;
   state_t d;
   logic [`PIN_W-1:0] pins;
   logic              rd;
   logic              wr;
   logic [7:0]        ev;
   logic [7:0]        b;
   dec_t              dc;

   // Byte registers selected by offset
   function automatic tgt_t reg_tgt(input logic [3:0] o);
      case (o)
         `OFF_ERR, `OFF_DUP_ERR: reg_tgt = T_ERR;
         `OFF_CNT:               reg_tgt = T_CNT;
         `OFF_LBL:               reg_tgt = T_LBL;
         `OFF_LBM:               reg_tgt = T_LBM;
         `OFF_LBH:               reg_tgt = T_LBH;
         `OFF_DHEAD, `OFF_CMD, `OFF_ALT, `OFF_DADDR: reg_tgt = T_EXT;
         default:                reg_tgt = T_NONE;
      endcase
   endfunction

   // Pin decode into target, offset and lanes
   function automatic dec_t decode(input mode_t m,
                                   input logic [`PIN_W-1:0] p,
                                   input logic bm);
      dec_t       r;
      logic [3:0] o;
      logic [2:0] a;
      logic       c1;
      logic       c2;
      r  = '{T_NONE, 4'h0, 1'b0, 1'b0};
      a  = p[`P_A0+2:`P_A0];
      c1 = !p[`P_CE1];
      c2 = !p[`P_CE2];
      o  = p[`P_A0+3:`P_A0];
      if (m == MODE_IDE) begin
         if (!p[`P_DMACK] && p[`P_CS0] && p[`P_CS1]) begin
            r = '{T_WORD, `OFF_DATA, 1'b1, 1'b1};
         end else if (p[`P_DMACK] && !p[`P_CS0] && p[`P_CS1]) begin
            r.off = {1'b0, a};
            r.lo  = 1'b1;
            if (a == 3'h0) begin
               r.tgt = bm ? T_SEQ : T_WORD;
               r.hi  = !bm;
            end else begin
               r.tgt = reg_tgt(r.off);
            end
         end else if (p[`P_DMACK] && p[`P_CS0] && !p[`P_CS1] &&
                      a == 3'b110) begin
            r = '{T_EXT, `OFF_ALT, 1'b1, 1'b0};
         end
      end else if (m != MODE_OFF && p[`P_REG] == (m == MODE_MEM)) begin
         if (m == MODE_MEM && p[`P_A10]) begin
            o = {3'b100, p[`P_A0]};
         end
         r.off = o;
         if (c1 && c2) begin
            r.lo  = 1'b1;
            r.hi  = 1'b1;
            if (o == `OFF_DATA || o == `OFF_DUP_EVEN || o == `OFF_DUP_ODD) begin
               r.tgt = T_WORD;
            end else if (o == `OFF_DUP_ERR) begin
               r.tgt = T_ERR;
               r.lo  = 1'b0;
            end else begin
               r.tgt = reg_tgt(o);
               r.hi  = 1'b0;
            end
         end else if (c1) begin
            r.lo = 1'b1;
            // byte at offset 1 is fault cause
            case (o)
               `OFF_DATA:     r.tgt = T_SEQ;
               `OFF_DUP_EVEN: r.tgt = T_EVEN;
               `OFF_DUP_ODD:  r.tgt = T_ODD;
               default:       r.tgt = reg_tgt(o);
            endcase
         end else if (c2) begin
            r.hi = 1'b1;
            if (o == `OFF_DATA) begin
               r.tgt = T_ERR;
            end else if (o == `OFF_DUP_EVEN || o == `OFF_DUP_ODD) begin
               r.tgt = T_ODD;
            end else begin
               r.tgt = o[0] ? reg_tgt(o) : T_NONE;
            end
         end
      end
      if (r.tgt == T_NONE) begin
         r.lo = 1'b0;
         r.hi = 1'b0;
      end
      decode = r;
   endfunction

   assign pins = {DATA_I, ADDR_I, DMACK_N_I, CS1_N_I, CS0_N_I, IOWR_N_I,
                  IORD_N_I, WE_N_I, OE_N_I, HIGH_BYTE_ENABLE_N_I,
                  LOW_BYTE_ENABLE_N_I, REG_N_I};

   // Strobes per mode, fault events
   always_comb begin
      if (mode_t'(MODE_I) == MODE_MEM) begin
         rd = !q.pin[`P_OE];
         wr = !q.pin[`P_WE];
      end else begin
         rd = !q.pin[`P_IORD];
         wr = !q.pin[`P_IOWR];
      end
      ev = 8'h00;
      ev[`ERR_BBK]  = BAD_BLOCK_I | CRC_ERR_I;
      ev[`ERR_UNC]  = UNCORR_I;
      ev[`ERR_SECTOR_NOT_FOUND_FLAG] = ID_NOT_FOUND_I;
      ev[`ERR_COMMAND_ABORTED_FLAG] = ABORT_I;
      ev[`ERR_GEN]  = GENERAL_ERR_I;
      dc = decode(mode_t'(MODE_I), q.pin, BYTE_MODE_I);
   end

   // Next state
   always_comb begin
      d      = q;
      d.s1   = pins;
      d.s2   = q.s1;
      d.s3   = q.s2;
      // Accept a pin change once stages two and three agree
      d.pin  = (q.s2 & ~(q.s2 ^ q.s3)) | (q.pin & (q.s2 ^ q.s3));
      d.pop  = 1'b0;
      d.push = 1'b0;
      d.fwr  = 1'b0;
      d.ewr  = 1'b0;
      b      = 8'h00;
      // Sector progress; host write below takes priority
      if (CMD_OK_I) begin
         d.cnt = 8'h00;
      end else if (SECTOR_DONE_I) begin
         // outstanding count, zero wraps from 256
         d.cnt = q.cnt - 8'h01;
      end
      case (q.phase)
         ST_IDLE: begin
            if (rd || wr) begin
               d.phase = ST_BUSY;
               d.dec   = dc;
               d.rd    = rd;
               d.wdat  = q.pin[`P_D0+15:`P_D0];
               d.eoff  = dc.off;
               if (rd) begin
                  case (dc.tgt)
                     T_WORD: begin
                        d.pop  = 1'b1;
                        d.dout = BUF_RD_DATA_I;
                     end
                     T_EVEN, T_ODD, T_SEQ: begin
                        if (dc.tgt == T_EVEN ||
                            (dc.tgt == T_SEQ && !q.half)) begin
                           d.pop  = 1'b1;
                           b      = BUF_RD_DATA_I[7:0];
                           d.hold = BUF_RD_DATA_I[15:8];
                           d.half = 1'b1;
                        end else begin
                           b      = q.hold;
                           d.half = 1'b0;
                        end
                        d.dout = {b, b};
                     end
                     T_ERR:   d.dout = {2{q.err & `ERR_MASK}};
                     T_CNT:   d.dout = {2{q.cnt}};
                     T_LBL:   d.dout = {2{q.lbl}};
                     T_LBM:   d.dout = {2{q.lbm}};
                     T_LBH:   d.dout = {2{q.lbh}};
                     T_EXT:   d.dout = {2{EXT_RDATA_I}};
                     default: d.dout = 16'h0000;
                  endcase
                  d.doe_n = {{8{!dc.hi}}, {8{!dc.lo}}};
               end
            end
         end
         ST_BUSY: begin
            if (!q.rd && wr) begin
               d.wdat = q.pin[`P_D0+15:`P_D0];
            end
            if (!(rd || wr)) begin
               d.phase = ST_IDLE;
               d.doe_n = 16'hffff;
               b       = q.dec.hi && !q.dec.lo ? q.wdat[15:8] : q.wdat[7:0];
               if (!q.rd) begin
                  case (q.dec.tgt)
                     T_WORD: begin
                        d.push = 1'b1;
                        d.bufw = q.wdat;
                     end
                     T_EVEN, T_ODD, T_SEQ: begin
                        if (q.dec.tgt == T_EVEN ||
                            (q.dec.tgt == T_SEQ && !q.half)) begin
                           d.hold = b;
                           d.half = 1'b1;
                        end else begin
                           d.push = 1'b1;
                           d.bufw = {b, q.hold};
                           d.half = 1'b0;
                        end
                     end
                     T_ERR: begin
                        d.feat = b;
                        d.fwr  = 1'b1;
                     end
                     T_CNT:   d.cnt = b;
                     T_LBL:   d.lbl = b;
                     T_LBM:   d.lbm = b;
                     T_LBH:   d.lbh = b;
                     T_EXT: begin
                        d.ewr = 1'b1;
                        d.ewd = b;
                     end
                     default: d.ewr = 1'b0;
                  endcase
                  // New command clears the previous fault
                  if (q.dec.tgt == T_EXT && q.dec.off == `OFF_CMD) begin
                     d.err  = 8'h00;
                     d.serr = 1'b0;
                  end
               end
            end
         end
         default: d.phase = ST_IDLE;
      endcase
      d.err  = (d.err | ev) & `ERR_MASK;
      d.serr = d.serr | (|ev);
      d.lba  = LBA_MODE_I ? {HEAD_I, q.lbh, q.lbm, q.lbl} : 28'h0000000;
      d.cyl  = LBA_MODE_I ? 16'h0000 : {q.lbh, q.lbm};
      d.sect = LBA_MODE_I ? 8'h00 : q.lbl;
   end

   // State register
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         q       <= '0;
         q.s1    <= {`PIN_W{1'b1}};
         q.s2    <= {`PIN_W{1'b1}};
         q.s3    <= {`PIN_W{1'b1}};
         q.pin   <= {`PIN_W{1'b1}};
         q.phase <= ST_IDLE;
         q.doe_n <= 16'hffff;
         q.feat  <= `FEAT_RST;
         q.cnt   <= `CNT_RST;
         q.lbl   <= `ADDR_RST;
         q.lbm   <= `ADDR_RST;
         q.lbh   <= `ADDR_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs
   assign DATA_O         = q.dout;
   assign DATA_OE_N_O    = q.doe_n;
   assign BUF_RD_READY_O = q.pop;
   assign BUF_WR_DATA_O  = q.bufw;
   assign BUF_WR_VALID_O = q.push;
   assign EXT_OFFSET_O   = q.eoff;
   assign EXT_WDATA_O    = q.ewd;
   assign EXT_WR_O       = q.ewr;
   assign FEATURE_O      = q.feat;
   assign FEATURE_WR_O   = q.fwr;
   assign SECTOR_COUNT_O = q.cnt;
   assign SECTOR_TOTAL_O = (q.cnt == 8'h00) ? 9'h100 : {1'b0, q.cnt};
   assign LBA_O          = q.lba;
   assign CYL_O          = q.cyl;
   assign SECT_O         = q.sect;
   assign ERROR_O        = q.err;
   assign STATUS_ERR_O   = q.serr;

   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   a_word_lanes: assert property (
      q.phase == ST_BUSY && q.rd && q.dec.tgt == T_WORD
      |-> DATA_OE_N_O == 16'h0000) else $error("word read not on both lanes");
   a_dma_word: assert property (
      q.phase == ST_IDLE && rd && MODE_I == MODE_IDE &&
      !q.pin[`P_DMACK] && q.pin[`P_CS0] && q.pin[`P_CS1]
      |=> DATA_OE_N_O == 16'h0000 && BUF_RD_READY_O)
      else $error("DMA read not a word");
   a_pop_pulse: assert property (
      BUF_RD_READY_O |=> !BUF_RD_READY_O) else $error("buffer pop repeated");
   a_reserved_zero: assert property (
      (ERROR_O & ~`ERR_MASK) == 8'h00) else $error("reserved bit set");
   a_crc_sets: assert property (
      CRC_ERR_I |=> ERROR_O[`ERR_BBK] && STATUS_ERR_O)
      else $error("CRC error not recorded");
   a_unc_sets: assert property (
      UNCORR_I |=> ERROR_O[`ERR_UNC]) else $error("uncorrectable lost");
   a_sector_not_found_flag_sets: assert property (
      ID_NOT_FOUND_I |=> ERROR_O[`ERR_SECTOR_NOT_FOUND_FLAG]) else $error("not found lost");
   a_abort_sets: assert property (
      ABORT_I |=> ERROR_O[`ERR_COMMAND_ABORTED_FLAG]) else $error("abort lost");
   a_gen_sets: assert property (
      GENERAL_ERR_I |=> ERROR_O[`ERR_GEN]) else $error("general error lost");
   a_status_cause: assert property (
      STATUS_ERR_O |-> ERROR_O != 8'h00) else $error("flag without cause");
   a_count_done: assert property (
      CMD_OK_I && q.phase == ST_IDLE |=> SECTOR_COUNT_O == 8'h00)
      else $error("count not zero on success");
   a_lba_form: assert property (
      LBA_MODE_I |=> LBA_O[27:24] == $past(HEAD_I) && CYL_O == 16'h0000)
      else $error("block address malformed");

   c_word_read: cover property (
      q.phase == ST_BUSY && q.rd && q.dec.tgt == T_WORD);
   c_byte_pair: cover property (
      BUF_WR_VALID_O && q.dec.tgt == T_SEQ);
   c_feature_hi: cover property (
      FEATURE_WR_O && q.dec.hi && !q.dec.lo);

endmodule // ata_task_file_decode

// file: rtl/ata_tf_cfg.svh
`ifndef ATA_TF_CFG_SVH
`define ATA_TF_CFG_SVH

// Task-file offsets
`define OFF_DATA      4'h0
`define OFF_ERR       4'h1
`define OFF_CNT       4'h2
`define OFF_LBL       4'h3
`define OFF_LBM       4'h4
`define OFF_LBH       4'h5
`define OFF_DHEAD     4'h6
`define OFF_CMD       4'h7
`define OFF_DUP_EVEN  4'h8
`define OFF_DUP_ODD   4'h9
`define OFF_DUP_ERR   4'hd
`define OFF_ALT       4'he
`define OFF_DADDR     4'hf

// Fault cause bit positions and the bits that exist
`define ERR_BBK       7
`define ERR_UNC       6
`define ERR_SECTOR_NOT_FOUND_FLAG      4
`define ERR_COMMAND_ABORTED_FLAG      2
`define ERR_GEN       0
`define ERR_MASK      8'hd5

// Reset values
`define CNT_RST       8'h01
`define ADDR_RST      8'h00
`define FEAT_RST      8'h00

// Pin vector layout after the synchroniser
`define PIN_W         37
`define P_REG         0
`define P_CE1         1
`define P_CE2         2
`define P_OE          3
`define P_WE          4
`define P_IORD        5
`define P_IOWR        6
`define P_CS0         7
`define P_CS1         8
`define P_DMACK       9
`define P_A0          10
`define P_A10         20
`define P_D0          21

`endif

// file: rtl/ata_tf_pkg.sv
`include "ata_tf_cfg.svh"
package ata_tf_pkg;
   // Bus personality of the card
   typedef enum logic [1:0] {
      MODE_MEM = 2'b00, MODE_IO = 2'b01, MODE_IDE = 2'b10, MODE_OFF = 2'b11
   } mode_t;
   // Decoded access target
   typedef enum logic [3:0] {
      T_NONE = 4'h0, T_WORD = 4'h1, T_EVEN = 4'h2, T_ODD = 4'h3,
      T_SEQ = 4'h4, T_ERR = 4'h5, T_CNT = 4'h6, T_LBL = 4'h7,
      T_LBM = 4'h8, T_LBH = 4'h9, T_EXT = 4'ha
   } tgt_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} phase_t;
   typedef struct packed {
      tgt_t       tgt;
      logic [3:0] off;
      logic       lo;
      logic       hi;
   } dec_t;
   typedef struct packed {
      logic [`PIN_W-1:0] s1;
      logic [`PIN_W-1:0] s2;
      logic [`PIN_W-1:0] s3;
      logic [`PIN_W-1:0] pin;
      phase_t            phase;
      logic              rd;
      dec_t              dec;
      logic [15:0]       wdat;
      logic [7:0]        hold;
      logic              half;
      logic [7:0]        feat;
      logic [7:0]        cnt;
      logic [7:0]        lbl;
      logic [7:0]        lbm;
      logic [7:0]        lbh;
      logic [7:0]        err;
      logic              serr;
      logic [15:0]       dout;
      logic [15:0]       doe_n;
      logic              pop;
      logic              push;
      logic [15:0]       bufw;
      logic              fwr;
      logic              ewr;
      logic [3:0]        eoff;
      logic [7:0]        ewd;
      logic [27:0]       lba;
      logic [15:0]       cyl;
      logic [7:0]        sect;
   } state_t;
endpackage

// file: sim/host_model.sv
module host_model
   import ata_tf_pkg::*;
(
   // Clock and card side
   input  wire logic        clk_i,
   input  wire logic [1:0]  mode_i,
   input  wire logic [15:0] data_i,
   input  wire logic [15:0] oe_n_i,
   // Host pins
   output logic             reg_n_o,
   output logic [4:0]       sel_n_o,
   output logic [3:0]       strb_n_o,
   output logic [10:0]      addr_o,
   output logic [15:0]      wdat_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic bad_reg;
   // Idle pins from time zero
   initial begin
      bad_reg = 1'b0;
      reg_n_o = 1'b1;
      sel_n_o = 5'h1f;
      strb_n_o = 4'hf;
      addr_o = 11'h000;
      wdat_o = 16'h0000;
   end
   // One access: strobe low six cycles, idle until the write has landed
   task automatic acc(input logic wr, input logic [4:0] sel,
                      input logic [10:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
      @(negedge clk_i);
      reg_n_o = (mode_i == MODE_MEM) ^ bad_reg;
      sel_n_o = sel;
      addr_o = a;
      wdat_o = wd;
      strb_n_o = (mode_i == MODE_MEM) ? (wr ? 4'hd : 4'he)
                                      : (wr ? 4'h7 : 4'hb);
      repeat (6) @(negedge clk_i);
      rd = data_i & ~oe_n_i;   // Undriven lanes read as zero
      strb_n_o = 4'hf;
      wdat_o = ~wd;            // Released bus stops showing the value
      repeat (3) @(negedge clk_i);
      sel_n_o = 5'h1f;
      repeat (3) @(negedge clk_i);   // Write pulses seen by the bench
   endtask
endmodule // host_model

// file: sim/testbench.sv
module testbench
   import ata_tf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] W = 5'h1c, L = 5'h1e, H = 5'h1d;
   localparam logic [4:0] C0 = 5'h1b, C1 = 5'h17, DM = 5'h0f;
   // Bench signals
   logic        clk, rst, byte_mode, lba_mode, reg_n, pop, bv;
   logic        ext_wr, feat_wr, serr;
   logic [1:0]  mode;
   logic [3:0]  head, strb_n, ext_off;
   logic [4:0]  sel_n;
   logic [7:0]  ev, ext_rd, ext_wd, feat, cnt, sect, err;
   logic [8:0]  tot;
   logic [10:0] addr;
   logic [15:0] wdat, dout, doe_n, buf_rd, bw, cyl, rd, last_push;
   logic [27:0] lba;
   int          n_errors, checks, npush, npop, nfw, nxw;
   int          ebit[6] = '{0, 2, 4, 6, 7, 7};

   ata_task_file_decode dut_u (
      .CLK_I(clk), .RST_I(rst), .MODE_I(mode), .BYTE_MODE_I(byte_mode),
      .REG_N_I(reg_n), .LOW_BYTE_ENABLE_N_I(sel_n[0]),
      .HIGH_BYTE_ENABLE_N_I(sel_n[1]), .OE_N_I(strb_n[0]),
      .WE_N_I(strb_n[1]), .IORD_N_I(strb_n[2]), .IOWR_N_I(strb_n[3]),
      .CS0_N_I(sel_n[2]), .CS1_N_I(sel_n[3]), .DMACK_N_I(sel_n[4]),
      .ADDR_I(addr), .DATA_I(wdat), .DATA_O(dout), .DATA_OE_N_O(doe_n),
      .BUF_RD_DATA_I(buf_rd), .BUF_RD_READY_O(pop), .BUF_WR_DATA_O(bw),
      .BUF_WR_VALID_O(bv), .BAD_BLOCK_I(ev[5]), .CRC_ERR_I(ev[4]),
      .UNCORR_I(ev[3]), .ID_NOT_FOUND_I(ev[2]), .ABORT_I(ev[1]),
      .GENERAL_ERR_I(ev[0]), .SECTOR_DONE_I(ev[6]), .CMD_OK_I(ev[7]),
      .LBA_MODE_I(lba_mode), .HEAD_I(head), .EXT_RDATA_I(ext_rd),
      .EXT_OFFSET_O(ext_off), .EXT_WDATA_O(ext_wd), .EXT_WR_O(ext_wr),
      .FEATURE_O(feat), .FEATURE_WR_O(feat_wr), .SECTOR_COUNT_O(cnt),
      .SECTOR_TOTAL_O(tot), .LBA_O(lba), .CYL_O(cyl), .SECT_O(sect),
      .ERROR_O(err), .STATUS_ERR_O(serr));

   host_model host_u (
      .clk_i(clk), .mode_i(mode), .data_i(dout), .oe_n_i(doe_n),
      .reg_n_o(reg_n), .sel_n_o(sel_n), .strb_n_o(strb_n),
      .addr_o(addr), .wdat_o(wdat));

   // Clock at 20 MHz
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Count buffer pushes, pops and register write pulses
   always @(posedge clk) begin
      if (bv === 1'b1) begin
         last_push <= bw;
         npush <= npush + 1;
      end
      if (pop === 1'b1) npop <= npop + 1;
      if (feat_wr === 1'b1) nfw <= nfw + 1;
      if (ext_wr === 1'b1) nxw <= nxw + 1;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h",
                  $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] s, input logic [10:0] a,
                     input logic [15:0] d);
      host_u.acc(1'b1, s, a, d, rd);
   endtask
   task automatic rdc(input logic [4:0] s, input logic [10:0] a,
                      input logic [15:0] e, input string m);
      host_u.acc(1'b0, s, a, 16'h0000, rd);
      chk(rd, e, m);
   endtask
   // One-cycle event pulse, then let it settle
   task automatic pulse(input logic [7:0] m);
      @(negedge clk);
      ev = m;
      @(negedge clk);
      ev = 8'h00;
      repeat (2) @(negedge clk);
   endtask
   task automatic fin(input string s);
      $display("test %s done, mismatches %0d", s, n_errors);
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      mode = MODE_MEM;
      byte_mode = 1'b0;
      lba_mode = 1'b0;
      ev = 8'h00;
      head = 4'ha;
      ext_rd = 8'h50;
      buf_rd = 16'h5a3c;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(cnt, 8'h01, "count reset");
      chk(err, 8'h00, "fault reset");
      // Byte registers with junk in the upper address bits
      for (int i = 0; i < 4; i++) begin
         wr(L, 11'h3f2 + 11'(i), 16'h0011 * 16'(i + 1));
         rdc(L, 11'h002 + 11'(i), 16'h0011 * 16'(i + 1), "reg");
      end
      lba_mode = 1'b1;
      repeat (2) @(negedge clk);
      chk(lba, 28'ha443322, "lba");
      lba_mode = 1'b0;
      repeat (2) @(negedge clk);
      chk(cyl, 16'h4433, "cyl");
      chk(sect, 8'h22, "sect");
      fin("registers");
      // Data port lanes and byte pairing
      rdc(W, 11'h000, 16'h5a3c, "word");
      rdc(L, 11'h000, 16'h003c, "even");
      rdc(L, 11'h000, 16'h005a, "odd");
      rdc(L, 11'h400, 16'h003c, "win even");
      rdc(L, 11'h401, 16'h005a, "win odd");
      chk(npop, 3, "pops");
      wr(L, 11'h400, 16'h0011);
      wr(L, 11'h401, 16'h0022);
      chk(last_push, 16'h2211, "byte push");
      wr(L, 11'h000, 16'h0033);
      wr(L, 11'h000, 16'h0044);
      chk(last_push, 16'h4433, "pair push");
      wr(W, 11'h000, 16'hbeef);
      chk(last_push, 16'hbeef, "word push");
      chk(npush, 3, "pushes");
      fin("data");
      // Option register loads, fault cause untouched
      wr(L, 11'h001, 16'h0081);
      chk(feat, 8'h81, "opt 1");
      wr(H, 11'h000, 16'h4200);
      chk(feat, 8'h42, "opt high");
      wr(L, 11'h00d, 16'h00d7);
      chk(feat, 8'hd7, "opt d");
      chk(nfw, 3, "opt pulses");
      chk(err, 8'h00, "fault ro");
      // Each fault event, cleared by a command write
      for (int i = 0; i < 6; i++) begin
         pulse(8'h01 << i);
         rdc(L, 11'h001, 16'h0001 << ebit[i], "cause");
         chk(serr, 1'b1, "status err");
         wr(L, 11'h007, 16'h0020);
         chk(err, 8'h00, "cleared");
         chk(serr, 1'b0, "flag cleared");
      end
      chk(nxw, 6, "command pulses");
      chk(ext_wd, 8'h20, "command byte");
      chk(ext_off, 4'h7, "command off");
      pulse(8'h3f);
      rdc(H, 11'h000, 16'hd500, "all causes");
      chk(err, 8'hd5, "zero bits");
      fin("faults");
      // Count semantics
      wr(L, 11'h002, 16'h0000);
      chk(tot, 9'h100, "256");
      pulse(8'h40);
      chk(cnt, 8'hff, "left");
      pulse(8'h80);
      chk(cnt, 8'h00, "done");
      // Wrong register select in I/O mode is ignored
      mode = MODE_IO;
      host_u.bad_reg = 1'b1;
      wr(L, 11'h002, 16'h0033);
      chk(cnt, 8'h00, "bad sel");
      host_u.bad_reg = 1'b0;
      wr(L, 11'h002, 16'h0033);
      chk(cnt, 8'h33, "io sel");
      fin("count");
      // True IDE decoding, DMA and byte mode
      mode = MODE_IDE;
      wr(C0, 11'h002, 16'h0007);
      rdc(C0, 11'h002, 16'h0007, "ide cnt");
      rdc(C1, 11'h006, 16'h0050, "alt");
      chk(ext_off, 4'he, "alt off");
      rdc(DM, 11'h003, 16'h5a3c, "dma");
      rdc(C0, 11'h000, 16'h5a3c, "pio word");
      byte_mode = 1'b1;
      rdc(C0, 11'h000, 16'h003c, "pio even");
      rdc(C0, 11'h000, 16'h005a, "pio odd");
      fin("ide");
      // Card switched off decodes nothing
      mode = MODE_OFF;
      wr(L, 11'h002, 16'h0055);
      chk(cnt, 8'h07, "off");
      fin("off");
      summarize();
   end
endmodule // testbench
